// ===== sbc_mode_and_output_timing.sv
`timescale 1ns/1ps
module sbc_mode_and_output_timing #(
   parameter int RESET_PULSE_CYCLES = sbc_pkg::RESET_PULSE_NS / sbc_pkg::CLK_PERIOD_NS,
   parameter int WAKE_PULSE_CYCLES  = sbc_pkg::WAKE_PULSE_NS / sbc_pkg::CLK_PERIOD_NS,
   parameter int PWM_LO_HALF_CYCLES = sbc_pkg::CLK_HZ / (2 * sbc_pkg::PWM_LO_HZ),
   parameter int PWM_HI_HALF_CYCLES = sbc_pkg::CLK_HZ / (2 * sbc_pkg::PWM_HI_HZ),
   parameter int TIMER_UNIT_CYCLES  = sbc_pkg::TIMER_UNIT_NS / sbc_pkg::CLK_PERIOD_NS
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   output logic             irq,
   input  wire logic        serial_clk,
   input  wire logic        frame_select_n,
   input  wire logic        serial_in,
   output logic             serial_out,
   output logic             serial_out_oe,
   input  wire logic        supply_por_ok,
   input  wire logic        wake_in,
   input  wire logic        wdog_fail,
   input  wire logic        main_regulator_uv,
   input  wire logic        reset_line_n_in,
   output logic             reset_out_n,
   output logic             reset_out_oe,
   output logic             wake_irq_n,
   output logic             main_regulator_en,
   output logic [2:0]       high_side_outputs,
   output logic [1:0]       low_side_outputs,
   output logic [1:0]       timer_out
);
   localparam int DRV_DELAY = sbc_pkg::DRV_DELAY_CYCLES;

   logic [4:0]          pin_meta;
   logic [4:0]          pin_sync;
   logic                wake_prev;
   logic                fault_prev;
   sbc_pkg::mode_t      mode;
   sbc_pkg::mode_t      next_mode;
   logic [19:0]         rst_cnt;
   logic [15:0]         wake_cnt;
   logic [10:0]         drv_cnt;
   logic [2:0]          pend_hs;
   logic [1:0]          pend_ls;
   logic [2:0]          hs_en;
   logic [1:0]          ls_en;
   logic [4:0]          pwm_freq_select;
   logic [1:0][2:0]     tim_per;
   logic [1:0][1:0]     tim_on;
   logic [4:0]          pwm;
   logic [4:0]          irq_status;
   logic [4:0]          irq_mask;
   logic                pwm_gate;
   logic                frame_valid;
   logic                frame_bad;
   sbc_pkg::frame_t     frame;

   wire supply_ok  = pin_sync[0];
   wire wake_rise  = pin_sync[1] & ~wake_prev;
   wire fault_lvl  = pin_sync[2] | pin_sync[3];
   wire fault_rise = fault_lvl & ~fault_prev;
   wire from_run   = (mode == sbc_pkg::MODE_NORMAL) || (mode == sbc_pkg::MODE_FLASH);
   wire from_idle  = (mode == sbc_pkg::MODE_INIT) || (mode == sbc_pkg::MODE_STANDBY);
   wire req_run    = frame.mode_req inside {sbc_pkg::MODE_NORMAL, sbc_pkg::MODE_STANDBY,
                                            sbc_pkg::MODE_SLEEP, sbc_pkg::MODE_FLASH};
   wire req_ok     = frame_valid && ((from_run && req_run) || (from_idle && frame.mode_req == sbc_pkg::MODE_NORMAL));
   wire wake_ev    = wake_rise && (mode == sbc_pkg::MODE_STANDBY || mode == sbc_pkg::MODE_SLEEP);
   wire rst_load   = supply_ok && (fault_rise || mode == sbc_pkg::MODE_OFF);
   wire [23:0] status_word = {mode, hs_en, ls_en, irq_status, pwm_freq_select, 6'h00};

   // Pins come from outside the clock domain
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_meta   <= sbc_pkg::PIN_SYNC_RESET;
         pin_sync   <= sbc_pkg::PIN_SYNC_RESET;
         wake_prev  <= 1'b0;
         fault_prev <= 1'b0;
      end else begin
         pin_meta   <= {reset_line_n_in, main_regulator_uv, wdog_fail, wake_in, supply_por_ok};
         pin_sync   <= pin_meta;
         wake_prev  <= pin_sync[1];
         fault_prev <= fault_lvl;
      end
   end

   sbc_spi_frame u_spi (
      .clk            (clk),
      .sys_rst        (sys_rst),
      .serial_clk     (serial_clk),
      .frame_select_n (frame_select_n),
      .serial_in      (serial_in),
      .status_word    (status_word),
      .serial_out     (serial_out),
      .serial_out_oe  (serial_out_oe),
      .frame_valid    (frame_valid),
      .frame_bad      (frame_bad),
      .frame          (frame)
   );

   always_comb begin
      next_mode = mode;
      if (!supply_ok) begin
         next_mode = sbc_pkg::MODE_OFF;
      end else begin
         unique case (mode)
            sbc_pkg::MODE_OFF: begin
               next_mode = sbc_pkg::MODE_INIT;
            end
            sbc_pkg::MODE_SLEEP: begin
               if (wake_rise) next_mode = sbc_pkg::MODE_INIT;
            end
            sbc_pkg::MODE_INIT, sbc_pkg::MODE_NORMAL, sbc_pkg::MODE_STANDBY, sbc_pkg::MODE_FLASH: begin
               if (fault_rise) begin
                  next_mode = sbc_pkg::MODE_INIT;
               end else if (req_ok) begin
                  next_mode = frame.mode_req;
               end
            end
            default: begin
               next_mode = sbc_pkg::MODE_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode              <= sbc_pkg::MODE_OFF;
         main_regulator_en <= 1'b0;
      end else begin
         mode              <= next_mode;
         main_regulator_en <= next_mode != sbc_pkg::MODE_OFF && next_mode != sbc_pkg::MODE_SLEEP;
      end
   end

   // Reset and wake pulses retrigger: a new cause restarts the full width
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rst_cnt      <= 20'h00000;
         wake_cnt     <= 16'h0000;
         reset_out_n  <= 1'b1;
         reset_out_oe <= 1'b0;
         wake_irq_n   <= 1'b1;
      end else begin
         if (rst_load) begin
            rst_cnt <= 20'(RESET_PULSE_CYCLES);
         end else if (rst_cnt != 20'h00000) begin
            rst_cnt <= rst_cnt - 20'h00001;
         end
         if (wake_ev) begin
            wake_cnt <= 16'(WAKE_PULSE_CYCLES);
         end else if (wake_cnt != 16'h0000) begin
            wake_cnt <= wake_cnt - 16'h0001;
         end
         reset_out_n  <= rst_cnt == 20'h00000;
         reset_out_oe <= rst_cnt != 20'h00000;
         wake_irq_n   <= wake_cnt == 16'h0000;
      end
   end

   // Driver switching and configuration follow a stored frame
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         drv_cnt         <= 11'h000;
         pend_hs         <= 3'h0;
         pend_ls         <= 2'h0;
         hs_en           <= 3'h0;
         ls_en           <= 2'h0;
         pwm_freq_select <= 5'h00;
         tim_per         <= '0;
         tim_on          <= '0;
      end else if (frame_valid) begin
         drv_cnt         <= 11'(DRV_DELAY);
         pend_hs         <= frame.hs_on;
         pend_ls         <= frame.ls_on;
         pwm_freq_select <= frame.pwm_freq_select;
         tim_per         <= {frame.timer2_period_sel, frame.timer1_period_sel};
         tim_on          <= {frame.timer2_on_sel, 1'b0, frame.timer1_on_sel};
      end else if (drv_cnt != 11'h000) begin
         drv_cnt <= drv_cnt - 11'h001;
         if (drv_cnt == 11'h001) begin
            hs_en <= pend_hs;
            ls_en <= pend_ls;
         end
      end
   end

   wire [4:0] gate = pwm_gate ? pwm : 5'h1F;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         high_side_outputs <= 3'h0;
         low_side_outputs  <= 2'h0;
      end else begin
         high_side_outputs <= hs_en & gate[2:0];
         low_side_outputs  <= ls_en & gate[4:3];
      end
   end

   for (genvar i = 0; i < 5; i++) begin : g_pwm
      sbc_pwm_gen #(
         .LO_HALF (PWM_LO_HALF_CYCLES),
         .HI_HALF (PWM_HI_HALF_CYCLES)
      ) u_pwm (
         .clk     (clk),
         .sys_rst (sys_rst),
         .freq_hi (pwm_freq_select[i]),
         .pwm_out (pwm[i])
      );
   end

   // Period is (select+1) units, on-time (select+1) quarter units
   for (genvar t = 0; t < 2; t++) begin : g_tim
      logic [23:0] cnt;
      wire [23:0] per_len = 24'(TIMER_UNIT_CYCLES) * 24'({1'b0, tim_per[t]} + 4'h1);
      wire [23:0] on_len  = 24'(TIMER_UNIT_CYCLES / 4) * 24'({2'b00, tim_on[t]} + 4'h1);
      always_ff @(posedge clk) begin
         if (sys_rst || cnt >= per_len - 24'h000001) begin
            cnt <= 24'h000000;
         end else begin
            cnt <= cnt + 24'h000001;
         end
         timer_out[t] <= !sys_rst && (cnt < on_len);
      end
   end

   // Avalon slave: one wait cycle, then the access completes
   wire         sel_status = address == sbc_pkg::REG_STATUS;
   wire         sel_irq    = address == sbc_pkg::REG_IRQ_STATUS;
   wire         sel_mask   = address == sbc_pkg::REG_IRQ_MASK;
   wire         sel_ctrl   = address == sbc_pkg::REG_CTRL;
   wire         wr_fire    = write & ~waitrequest;
   wire [4:0]   w1c        = (wr_fire && sel_irq) ? writedata[4:0] : 5'h00;
   wire [4:0]   events     = {next_mode != mode, rst_load, wake_ev, frame_bad, frame_valid};
   wire [4:0]   next_irq   = (irq_status & ~w1c) | events;
   wire [31:0]  rd_status  = {16'h0000, pin_sync[4], reset_out_n, wake_irq_n, hs_en, ls_en,
                              pwm_freq_select, mode};
   wire [31:0]  rd_mux     = sel_status ? rd_status :
                             sel_irq    ? {27'h0000000, irq_status} :
                             sel_mask   ? {27'h0000000, irq_mask} :
                             sel_ctrl   ? {31'h00000000, pwm_gate} : 32'h00000000;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h00000000;
         irq_status  <= 5'h00;
         irq_mask    <= sbc_pkg::IRQ_MASK_RESET;
         pwm_gate    <= sbc_pkg::CTRL_GATE_RESET;
         irq         <= 1'b0;
      end else begin
         waitrequest <= ~((read | write) & waitrequest);
         if (read & waitrequest) readdata <= rd_mux;
         if (wr_fire && sel_mask) irq_mask <= writedata[4:0];
         if (wr_fire && sel_ctrl) pwm_gate <= writedata[0];
         irq_status <= next_irq;
         irq        <= |(next_irq & irq_mask);
      end
   end

   logic [19:0] rst_low_len;
   logic [15:0] wake_low_len;
   logic [10:0] since_frame;
   always_ff @(posedge clk) begin
      rst_low_len  <= (sys_rst || reset_out_n) ? 20'h00000 : rst_low_len + 20'h00001;
      wake_low_len <= (sys_rst || wake_irq_n) ? 16'h0000 : wake_low_len + 16'h0001;
      since_frame  <= (sys_rst || frame_valid) ? 11'h000 : since_frame + 11'(since_frame != 11'h7FF);
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_powerup;
      $rose(supply_ok) && mode == sbc_pkg::MODE_OFF |=> mode == sbc_pkg::MODE_INIT && main_regulator_en;
   endproperty
   a_powerup: assert property (p_powerup) else $error("no Init after supply rise");

   property p_standby;
      frame_valid && from_run && frame.mode_req == sbc_pkg::MODE_STANDBY && supply_ok && !fault_rise
         |=> mode == sbc_pkg::MODE_STANDBY;
   endproperty
   a_standby: assert property (p_standby) else $error("Standby not entered");

   property p_sleep;
      frame_valid && from_run && frame.mode_req == sbc_pkg::MODE_SLEEP && supply_ok && !fault_rise
         |=> mode == sbc_pkg::MODE_SLEEP && !main_regulator_en;
   endproperty
   a_sleep: assert property (p_sleep) else $error("Sleep not entered");

   sequence s_wake_standby;
      wake_rise && mode == sbc_pkg::MODE_STANDBY;
   endsequence
   property p_wake_irq;
      s_wake_standby |-> ##[1:2] !wake_irq_n;
   endproperty
   a_wake_irq: assert property (p_wake_irq) else $error("wake pulse late");

   property p_sleep_wake;
      wake_rise && mode == sbc_pkg::MODE_SLEEP && supply_ok |=> mode == sbc_pkg::MODE_INIT;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("Sleep wake did not reach Init");

   property p_reset_width;
      $rose(reset_out_n) |-> rst_low_len >= 20'(RESET_PULSE_CYCLES) && !reset_out_oe;
   endproperty
   a_reset_width: assert property (p_reset_width) else $error("reset pulse too short");

   property p_wake_width;
      $rose(wake_irq_n) |-> wake_low_len >= 16'(WAKE_PULSE_CYCLES);
   endproperty
   a_wake_width: assert property (p_wake_width) else $error("wake pulse too short");

   property p_hs_delay;
      $changed(hs_en) |-> since_frame == 11'(DRV_DELAY);
   endproperty
   a_hs_delay: assert property (p_hs_delay) else $error("high-side switched at wrong time");

   property p_ls_delay;
      $changed(ls_en) |-> since_frame == 11'(DRV_DELAY);
   endproperty
   a_ls_delay: assert property (p_ls_delay) else $error("low-side switched at wrong time");

   property p_exec;
      frame_valid |=> tim_per == {$past(frame.timer2_period_sel), $past(frame.timer1_period_sel)};
   endproperty
   a_exec: assert property (p_exec) else $error("frame not executed");
endmodule

// ===== sbc_mode_and_output_timing_tb_top.sv
`timescale 1ns/1ps
module sbc_mode_and_output_timing_tb_top;
   logic        clk = 1'b0, sys_rst = 1'b1, read = 1'b0, write = 1'b0;
   logic [3:0]  address = 4'h0;
   logic [31:0] writedata = 32'h0, readdata, rd;
   logic        waitrequest, irq, serial_clk, frame_select_n, serial_in, serial_out, serial_out_oe;
   logic        supply_por_ok = 1'b1, wake_in = 1'b0, wdog_fail = 1'b0, main_regulator_uv = 1'b0;
   logic        reset_line_n_in, reset_out_n, reset_out_oe, wake_irq_n, main_regulator_en;
   logic [2:0]  high_side_outputs;
   logic [1:0]  low_side_outputs, timer_out;
   logic [23:0] rx;
   int          n_errors = 0, checks_done = 0, len;
   // Open-drain reset line with pull-up
   assign reset_line_n_in = reset_out_oe ? 1'b0 : 1'b1;
   wire [6:0] watch = {timer_out, low_side_outputs, high_side_outputs};
   always #12.5 clk = ~clk;
   sbc_mode_and_output_timing #(.RESET_PULSE_CYCLES(40), .WAKE_PULSE_CYCLES(20), .PWM_LO_HALF_CYCLES(30),
      .PWM_HI_HALF_CYCLES(20), .TIMER_UNIT_CYCLES(64)) dut (.*);
   sbc_spi_host host (.*);
   task automatic complete_run;
      if (n_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= ~wr;
      write <= wr;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wait_mode(input sbc_pkg::mode_t m, input int lim);
      int t;
      t = 0;
      do begin
         bus(1'b0, sbc_pkg::REG_STATUS, 32'h0);
         t += 3;
      end while (rd[2:0] !== m && t < lim);
      cmp(rd[2:0], m);
   endtask
   task automatic pulse(input bit rst, input int lim);
      int t;
      t = 0;
      len = 0;
      while ((rst ? reset_out_n : wake_irq_n) !== 1'b0 && t < lim) begin
         @(posedge clk);
         t++;
      end
      cmp({t < lim, rst ? reset_out_oe : 1'b1}, 32'h3);
      while ((rst ? reset_out_n : wake_irq_n) === 1'b0 && len < 1000) begin
         @(posedge clk);
         len++;
      end
   endtask
   // Skips a partial level so only a whole one is measured
   task automatic level_len(input int b, input logic v);
      len = 0;
      while (watch[b] === v) @(posedge clk);
      while (watch[b] !== v) @(posedge clk);
      while (watch[b] === v && len < 1000) begin
         @(posedge clk);
         len++;
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      cmp({waitrequest, reset_out_n, wake_irq_n, main_regulator_en}, 32'hE);
      sys_rst <= 1'b0;
      wait_mode(sbc_pkg::MODE_INIT, 600);
      cmp(main_regulator_en, 32'h1);
      bus(1'b0, 4'h2, 32'h0);
      cmp(rd, 32'h0);
      bus(1'b1, sbc_pkg::REG_IRQ_MASK, 32'h2);
      bus(1'b0, sbc_pkg::REG_IRQ_MASK, 32'h0);
      cmp(rd, 32'h2);
      host.send({sbc_pkg::MODE_NORMAL, 3'h5, 2'h2, 5'h01, 11'h1B8}, 24, rx);
      wait_mode(sbc_pkg::MODE_NORMAL, 1000);
      repeat (460) @(posedge clk);
      cmp(high_side_outputs, 32'h0);
      repeat (200) @(posedge clk);
      cmp(low_side_outputs, 32'h0);
      repeat (920) @(posedge clk);
      cmp({high_side_outputs, low_side_outputs}, 32'h16);
      bus(1'b0, sbc_pkg::REG_STATUS, 32'h0);
      cmp(rd, 32'hF60A);
      bus(1'b1, sbc_pkg::REG_CTRL, 32'h1);
      level_len(0, 1'b1);
      cmp(len, 32'h14);
      level_len(2, 1'b1);
      cmp(len, 32'h1E);
      bus(1'b1, sbc_pkg::REG_CTRL, 32'h0);
      level_len(5, 1'b1);
      cmp(len, 32'h20);
      level_len(5, 1'b0);
      cmp(len, 32'h60);
      level_len(6, 1'b1);
      cmp(len, 32'h30);
      // Short frame must leave the mode alone and flag itself
      host.send({sbc_pkg::MODE_SLEEP, 21'h0}, 23, rx);
      repeat (20) @(posedge clk);
      bus(1'b0, sbc_pkg::REG_IRQ_STATUS, 32'h0);
      cmp({irq, rd[1]}, 32'h3);
      bus(1'b1, sbc_pkg::REG_IRQ_STATUS, 32'h2);
      bus(1'b0, sbc_pkg::REG_IRQ_STATUS, 32'h0);
      cmp({irq, rd[1]}, 32'h0);
      wait_mode(sbc_pkg::MODE_NORMAL, 3);
      host.send({sbc_pkg::MODE_STANDBY, 21'h0}, 24, rx);
      cmp(rx[23:21], sbc_pkg::MODE_NORMAL);
      wait_mode(sbc_pkg::MODE_STANDBY, 400);
      wake_in <= 1'b1;
      pulse(1'b0, 400);
      cmp(len >= 17 && len <= 23, 32'h1);
      wake_in <= 1'b0;
      repeat (600) @(posedge clk);
      cmp({high_side_outputs, low_side_outputs}, 32'h16);
      repeat (1580) @(posedge clk);
      cmp({high_side_outputs, low_side_outputs}, 32'h0);
      host.send({sbc_pkg::MODE_NORMAL, 21'h0}, 24, rx);
      wait_mode(sbc_pkg::MODE_NORMAL, 1000);
      host.send({sbc_pkg::MODE_FLASH, 21'h0}, 24, rx);
      wait_mode(sbc_pkg::MODE_FLASH, 1000);
      host.send({sbc_pkg::MODE_SLEEP, 21'h0}, 24, rx);
      wait_mode(sbc_pkg::MODE_SLEEP, 400);
      wake_in <= 1'b1;
      wait_mode(sbc_pkg::MODE_INIT, 400);
      wdog_fail <= 1'b1;
      pulse(1'b1, 200);
      cmp(len >= 34 && len <= 46, 32'h1);
      cmp(reset_out_oe, 32'h0);
      complete_run();
   end
   initial begin
      repeat (50000) @(posedge clk);
      n_errors++;
      complete_run();
   end
endmodule

// ===== sbc_pkg.sv
package sbc_pkg;
   localparam int CLK_HZ           = 40_000_000;
   localparam int CLK_PERIOD_NS    = 25;
   localparam int POWERUP_MAX_NS   = 15_000;
   localparam int MODE_MAX_NS      = 10_000;
   localparam int EXEC_MAX_NS      = 25_000;
   // One delay serves both driver kinds: it sits inside every on and off window
   localparam int DRV_DELAY_NS     = 30_000;
   localparam int DRV_DELAY_CYCLES = DRV_DELAY_NS / CLK_PERIOD_NS;
   localparam int RESET_PULSE_NS   = 2_000_000;
   localparam int WAKE_PULSE_NS    = 125_000;
   localparam int PWM_LO_HZ        = 150;
   localparam int PWM_HI_HZ        = 200;
   localparam int TIMER_UNIT_NS    = 10_000_000;
   localparam int FRAME_BITS       = 24;

   localparam logic [3:0] REG_STATUS     = 4'h0;
   localparam logic [3:0] REG_IRQ_STATUS = 4'h4;
   localparam logic [3:0] REG_IRQ_MASK   = 4'h8;
   localparam logic [3:0] REG_CTRL       = 4'hC;

   localparam int IRQ_FRAME_OK  = 0;
   localparam int IRQ_FRAME_BAD = 1;
   localparam int IRQ_WAKE      = 2;
   localparam int IRQ_RESET     = 3;
   localparam int IRQ_MODE      = 4;
   localparam int IRQ_BITS      = 5;

   localparam logic [4:0] IRQ_MASK_RESET  = 5'h00;
   localparam logic       CTRL_GATE_RESET = 1'b0;
   localparam logic [4:0] PIN_SYNC_RESET  = 5'h10;
   localparam logic [2:0] SPI_SYNC_RESET  = 3'h2;

   typedef enum logic [2:0] {
      MODE_OFF     = 3'b000,
      MODE_INIT    = 3'b001,
      MODE_NORMAL  = 3'b010,
      MODE_STANDBY = 3'b011,
      MODE_SLEEP   = 3'b100,
      MODE_FLASH   = 3'b101
   } mode_t;

   typedef struct packed {
      mode_t      mode_req;
      logic [2:0] hs_on;
      logic [1:0] ls_on;
      logic [4:0] pwm_freq_select;
      logic [2:0] timer1_period_sel;
      logic       timer1_on_sel;
      logic [2:0] timer2_period_sel;
      logic [1:0] timer2_on_sel;
      logic [1:0] spare;
   } frame_t;
endpackage

// ===== sbc_pwm_gen.sv
`timescale 1ns/1ps
module sbc_pwm_gen #(
   parameter int LO_HALF = 133333,
   parameter int HI_HALF = 100000
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic freq_hi,
   output logic      pwm_out
);
   logic [17:0] cnt;
   logic        pwm_d;
   logic [17:0] run;
   logic        fsel_moved;
   logic        freq_d;

   wire [17:0] half = freq_hi ? 18'(HI_HALF - 1) : 18'(LO_HALF - 1);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt     <= 18'h00000;
         pwm_out <= 1'b0;
      end else if (cnt >= half) begin
         cnt     <= 18'h00000;
         pwm_out <= ~pwm_out;
      end else begin
         cnt <= cnt + 18'h00001;
      end
   end

   // Helper for the period check; a select change mid-period is excused once
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pwm_d      <= 1'b0;
         run        <= 18'h00000;
         fsel_moved <= 1'b1;
         freq_d     <= 1'b0;
      end else begin
         pwm_d      <= pwm_out;
         freq_d     <= freq_hi;
         run        <= (pwm_out != pwm_d) ? 18'h00001 : run + 18'h00001;
         fsel_moved <= (pwm_out != pwm_d) ? (freq_hi != freq_d) : (fsel_moved | (freq_hi != freq_d));
      end
   end

   property p_pwm_half;
      @(posedge clk) disable iff (sys_rst)
      (pwm_out != pwm_d) && !fsel_moved && (freq_hi == freq_d) |-> run == half + 18'h00001;
   endproperty
   a_pwm_half: assert property (p_pwm_half) else $error("pwm half period off its setting");
endmodule

// ===== sbc_spi_frame.sv
`timescale 1ns/1ps
module sbc_spi_frame (
   input  wire logic            clk,
   input  wire logic            sys_rst,
   input  wire logic            serial_clk,
   input  wire logic            frame_select_n,
   input  wire logic            serial_in,
   input  wire logic [23:0]     status_word,
   output logic                 serial_out,
   output logic                 serial_out_oe,
   output logic                 frame_valid,
   output logic                 frame_bad,
   output sbc_pkg::frame_t      frame
);
   logic [2:0]  pin_meta;
   logic [2:0]  pin_sync;
   logic        sclk_prev;
   logic        cs_n_prev;
   logic [4:0]  bit_cnt;
   logic [23:0] shift_in;
   logic [23:0] shift_out;

   // Link clock is only sampled; 8 system clocks per link period leave margin
   wire sclk_rise = pin_sync[2] & ~sclk_prev;
   wire sclk_fall = ~pin_sync[2] & sclk_prev;
   wire cs_start  = ~pin_sync[1] & cs_n_prev;
   wire cs_end    = pin_sync[1] & ~cs_n_prev;
   wire active    = ~pin_sync[1];
   wire full_len  = bit_cnt == 5'(sbc_pkg::FRAME_BITS);
   wire cnt_room  = bit_cnt != 5'h1F;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_meta  <= sbc_pkg::SPI_SYNC_RESET;
         pin_sync  <= sbc_pkg::SPI_SYNC_RESET;
         sclk_prev <= 1'b0;
         cs_n_prev <= 1'b1;
      end else begin
         pin_meta  <= {serial_clk, frame_select_n, serial_in};
         pin_sync  <= pin_meta;
         sclk_prev <= pin_sync[2];
         cs_n_prev <= pin_sync[1];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bit_cnt       <= 5'h00;
         shift_in      <= 24'h000000;
         shift_out     <= 24'h000000;
         serial_out    <= 1'b0;
         serial_out_oe <= 1'b0;
         frame_valid   <= 1'b0;
         frame_bad     <= 1'b0;
         frame         <= '0;
      end else begin
         frame_valid   <= cs_end & full_len;
         frame_bad     <= cs_end & ~full_len;
         serial_out_oe <= active;
         if (cs_end & full_len) begin
            frame <= sbc_pkg::frame_t'(shift_in);
         end
         if (cs_start) begin
            bit_cnt    <= 5'h00;
            serial_out <= status_word[23];
            shift_out  <= {status_word[22:0], 1'b0};
         end else if (active) begin
            if (sclk_rise & cnt_room) begin
               bit_cnt  <= bit_cnt + 5'h01;
               shift_in <= {shift_in[22:0], pin_sync[0]};
            end
            if (sclk_fall) begin
               serial_out <= shift_out[23];
               shift_out  <= {shift_out[22:0], 1'b0};
            end
         end
      end
   end

   property p_frame_len;
      @(posedge clk) disable iff (sys_rst)
      frame_valid |-> $past(bit_cnt) == 5'h18;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame accepted with wrong bit count");

   property p_out_on_fall;
      @(posedge clk) disable iff (sys_rst)
      $changed(serial_out) |-> $past(sclk_fall) || $past(cs_start);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall) else $error("serial output moved off a falling edge");
endmodule

// ===== sbc_spi_host.sv
`timescale 1ns/1ps
module sbc_spi_host (
   input  wire logic clk,
   input  wire logic serial_out,
   output logic      serial_clk,
   output logic      frame_select_n,
   output logic      serial_in
);
   initial {serial_clk, frame_select_n, serial_in} = 3'h2;
   // Clock idles low, 500 ns halves: slower than needed but safely legal
   task automatic send(input logic [23:0] w, input int n, output logic [23:0] rx);
      rx = 24'h0;
      repeat (240) @(posedge clk);
      frame_select_n <= 1'b0;
      repeat (10) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         serial_in <= w[23 - i];
         repeat (20) @(posedge clk);
         serial_clk <= 1'b1;
         rx = {rx[22:0], serial_out};
         repeat (20) @(posedge clk);
         serial_clk <= 1'b0;
      end
      repeat (10) @(posedge clk);
      frame_select_n <= 1'b1;
      serial_in <= ~serial_in; // Released line shows no stale bit
   endtask
endmodule
